/* verilog/trs_pkg.sv */
// Operation
// - data not ready: respond status byte then check byte, payload count zero.
// - response without payload is padded with fill bytes to full length.
// - status bit 0 busy while data pending, cleared when the result returns, with or without payload.
// - uninterpretable command with none pending sets status bit 1 and returns no payload.
// - command arriving before previous completes sets status bit 3, no payload.
// - a read after a command's result reports its failure in status bit 1; write and read commands are not told apart.
`default_nettype none
package trs_pkg;
	localparam int RESP_LEN = 8;
	localparam logic [3:0] RESP_LEN_W = 4'h8;
	localparam int PAY_MAX = 5;
	localparam int BIT_BUSY = 0;
	localparam int BIT_ERR = 1;
	localparam int BIT_REJ = 3;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STAT = 2'b01,
		ST_BODY = 2'b11,
		ST_PAD = 2'b10
	} trs_state_e;

	// command as delivered by the telegram receiver
	typedef struct packed {
		logic valid;
		logic bad;
		logic isWrite;
	} trs_cmd_s;

	// result from the executing function
	typedef struct packed {
		logic done;
		logic ok;
		logic [2:0] count;
		logic [PAY_MAX*8-1:0] data;
	} trs_res_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} trs_byte_s;
endpackage : trs_pkg
`default_nettype wire

/* verilog/trs_crc.sv */
`default_nettype none
module trs_crc
	import trs_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic sys_rst, // sync reset, high
	input wire logic clear, // restart checksum
	input wire logic enable, // fold in data byte
	input wire logic [7:0] data, // byte to fold
	output logic [7:0] crc // running checksum
);
	logic [7:0] crc_r;
	logic [7:0] crc_nxt;

	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) begin
			x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
		end
		return x;
	endfunction : crcStep

	always_comb begin
		crc_nxt = crc_r;
		if (clear) begin
			// clear with enable seeds from the first byte, so it folds in the cycle it is loaded
			crc_nxt = enable ? crcStep(CRC_INIT, data) : CRC_INIT;
		end else if (enable) begin
			crc_nxt = crcStep(crc_r, data);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			crc_r <= CRC_INIT;
		end else begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;
endmodule : trs_crc
`default_nettype wire

/* verilog/trs_responder.sv */
`default_nettype none
module trs_responder
	import trs_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic sys_rst, // sync reset, high
	input wire trs_cmd_s cmdIn, // new command pulse from receiver
	input wire trs_res_s resIn, // execution result pulse
	input wire logic readStart, // host begins a read transfer, pulse
	input wire logic byteAck, // host took current byte, pulse
	output trs_byte_s txByte, // byte offered to the bus shifter
	output logic [7:0] status, // live system status byte
	output logic execStart // start the executing function, pulse
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		trs_state_e st;
		logic [7:0] status;
		logic pending;
		logic [2:0] count;
		logic [PAY_MAX*8-1:0] data;
		logic [3:0] idx;
		logic [2:0] sent;
		trs_byte_s tx;
		logic start;
	} trs_regs_s;

	trs_regs_s q_r;
	trs_regs_s q_nxt;
	logic crcClear;
	logic crcEn;
	logic [7:0] crcVal;

	function automatic logic [7:0] payByte(input logic [PAY_MAX*8-1:0] d, input logic [2:0] i);
		return d[8*i +: 8];
	endfunction : payByte

	trs_crc uCrc (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clear(crcClear),
		.enable(crcEn),
		.data(q_nxt.tx.data),
		.crc(crcVal)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		q_nxt = q_r;
		q_nxt.start = 1'b0;
		crcClear = 1'b0;
		crcEn = 1'b0;
		// result before command: a finishing job frees the slot first
		if (resIn.done && q_r.pending) begin
			q_nxt.pending = 1'b0;
			q_nxt.status[BIT_BUSY] = 1'b0;
			q_nxt.status[BIT_ERR] = ~resIn.ok;
			q_nxt.count = resIn.ok ? resIn.count : 3'h0;
			q_nxt.data = resIn.data;
		end
		if (cmdIn.valid) begin
			if (q_nxt.pending) begin
				// running job untouched; only flagged
				q_nxt.status[BIT_REJ] = 1'b1;
			end else if (cmdIn.bad) begin
				q_nxt.status = STATUS_RST;
				q_nxt.status[BIT_ERR] = 1'b1;
				q_nxt.count = 3'h0;
			end else begin
				q_nxt.status = STATUS_RST;
				q_nxt.status[BIT_BUSY] = 1'b1;
				q_nxt.pending = 1'b1;
				q_nxt.count = 3'h0;
				q_nxt.start = 1'b1;
			end
		end
		case (q_r.st)
			ST_IDLE: begin
				q_nxt.tx = '0;
				if (readStart) begin
					// reads never start work, only snapshot status
					q_nxt.st = ST_STAT;
					q_nxt.tx.valid = 1'b1;
					q_nxt.tx.data = q_nxt.status;
					q_nxt.idx = 4'h1;
					q_nxt.sent = 3'h0;
					crcClear = 1'b1;
					// bytes fold as they are loaded, so the check byte is ready when needed
					crcEn = 1'b1;
				end
			end
			ST_STAT: begin
				if (byteAck) begin
					q_nxt.st = ST_BODY;
					// busy/error/reject: no payload bytes
					if (q_r.tx.data[BIT_BUSY] || q_r.tx.data[BIT_ERR] || q_r.tx.data[BIT_REJ] ||
						q_r.count == 3'h0) begin
						q_nxt.sent = 3'h0;
					end else begin
						q_nxt.sent = q_r.count;
					end
					q_nxt.tx.data = (q_nxt.sent == 3'h0) ? crcVal : payByte(q_r.data, 3'h0);
					crcEn = (q_nxt.sent != 3'h0);
					q_nxt.idx = q_r.idx + 4'h1;
				end
			end
			ST_BODY: begin
				if (byteAck) begin
					q_nxt.idx = q_r.idx + 4'h1;
					// idx is the position of the byte now being loaded
					if (q_r.idx <= {1'b0, q_r.sent}) begin
						crcEn = 1'b1;
						q_nxt.tx.data = payByte(q_r.data, q_r.idx[2:0] - 3'h1);
					end else if (q_r.idx == {1'b0, q_r.sent} + 4'h1) begin
						q_nxt.tx.data = crcVal;
					end else begin
						q_nxt.st = ST_PAD;
						q_nxt.tx.data = FILL_BYTE;
					end
					if (q_r.idx == RESP_LEN_W - 4'h1) begin
						q_nxt.tx.last = 1'b1;
					end
				end
			end
			ST_PAD: begin
				if (byteAck) begin
					q_nxt.idx = q_r.idx + 4'h1;
					q_nxt.tx.data = FILL_BYTE;
					if (q_r.idx == RESP_LEN_W - 4'h1) begin
						q_nxt.tx.last = 1'b1;
					end
				end
			end
			default: begin
				q_nxt.st = ST_IDLE;
			end
		endcase
		if (q_r.st != ST_IDLE && byteAck && q_r.tx.last) begin
			q_nxt.st = ST_IDLE;
			q_nxt.tx = '0;
			// reject is cleared when any read ends, even one whose status byte lacked it; a new reject in the same cycle wins
			if (!(cmdIn.valid && q_nxt.pending && q_r.pending)) begin
				q_nxt.status[BIT_REJ] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign txByte = q_r.tx;
	assign status = q_r.status;
	assign execStart = q_r.start;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_readBusy;
		readStart && q_r.st == ST_IDLE && q_nxt.status[BIT_BUSY];
	endsequence

	sequence s_noPayAck;
		q_r.st == ST_STAT && byteAck && q_nxt.sent == 3'h0;
	endsequence

	sequence s_crcAck;
		q_r.st == ST_BODY && byteAck;
	endsequence

	a_busy_first_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_readBusy |=> txByte.valid && txByte.data[BIT_BUSY])
		else $error("busy not shown in first byte");
	a_busy_no_payload: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q_r.st == ST_STAT && byteAck && txByte.data[BIT_BUSY]) |=> q_r.sent == 3'h0 && txByte.data == crcVal)
		else $error("busy response carried payload");
	a_err_no_payload: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q_r.st == ST_STAT && byteAck && txByte.data[BIT_ERR]) |=> q_r.sent == 3'h0)
		else $error("error response carried payload");
	a_rej_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmdIn.valid && q_r.pending && !resIn.done) |=> status[BIT_REJ] && !execStart)
		else $error("reject not flagged");
	a_rej_no_payload: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q_r.st == ST_STAT && byteAck && txByte.data[BIT_REJ]) |=> q_r.sent == 3'h0)
		else $error("reject response carried payload");
	a_pad_fill: assert property (@(posedge sys_clk) disable iff (sys_rst)
		q_r.st == ST_PAD |-> txByte.data == FILL_BYTE)
		else $error("pad byte not fill value");
	a_len_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst)
		txByte.last |-> q_r.idx == RESP_LEN_W)
		else $error("response length wrong");
	a_read_no_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(readStart && !cmdIn.valid) |=> !execStart)
		else $error("read restarted command");
	a_done_reports: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(resIn.done && q_r.pending && !cmdIn.valid) |=> !status[BIT_BUSY] && status[BIT_ERR] == !$past(resIn.ok))
		else $error("completion not reported");
	a_busy_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q_r.pending && !resIn.done) |=> status[BIT_BUSY])
		else $error("busy dropped early");
	a_nopay_then_fill: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_noPayAck ##1 s_crcAck |=> q_r.st == ST_PAD && txByte.data == FILL_BYTE)
		else $error("no fill after check byte");
	a_good_sets_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmdIn.valid && !cmdIn.bad && !q_r.pending) |=> status[BIT_BUSY] && !status[BIT_ERR] && execStart)
		else $error("accepted command not busy");
	a_bad_sets_err: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmdIn.valid && cmdIn.bad && !q_r.pending) |=> status[BIT_ERR] && !status[BIT_BUSY] && !execStart)
		else $error("bad command not flagged");
	a_start_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
		execStart |-> $past(cmdIn.valid && !cmdIn.bad))
		else $error("start without command");
	a_rej_cleared: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q_r.st != ST_IDLE && byteAck && txByte.last && !cmdIn.valid) |=> !status[BIT_REJ])
		else $error("reject flag not cleared");
endmodule : trs_responder
`default_nettype wire

/* dv/trs_host_model.sv */
`default_nettype none
module trs_host_model import trs_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire trs_byte_s txByte, // byte offered by device
	output logic readStart, // begin read, pulse
	output logic byteAck // byte taken, pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		readStart = 1'b0;
		byteAck = 1'b0;
	end
	// ----
	// fixed-length read, repeatable at will for polling
	// ----
	task automatic do_read(output logic [63:0] r, output bit hung);
		int w;
		hung = 0;
		r = '0;
		readStart = 1'b1;
		@(negedge sys_clk);
		readStart = 1'b0;
		for (int i = 0; i < RESP_LEN; i++) begin
			w = 0;
			while (txByte.valid !== 1'b1 && w < 20) begin
				// nothing on offer: drop the ack so no byte is taken twice
				byteAck = 1'b0;
				@(negedge sys_clk);
				w++;
			end
			hung |= (w == 20) || (txByte.last !== (i == RESP_LEN - 1));
			r[8*i+:8] = txByte.data;
			byteAck = 1'b1;
			@(negedge sys_clk);
		end
		byteAck = 1'b0;
	endtask : do_read
endmodule : trs_host_model
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top import trs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	trs_cmd_s cmdIn = '0;
	trs_res_s resIn = '0;
	logic readStart;
	logic byteAck;
	trs_byte_s txByte;
	logic [7:0] status;
	logic execStart;
	int fails = 0;
	int n_compared = 0;
	int nExec = 0;
	int cnt;
	int e0;
	logic [39:0] pay;
	always #2.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (execStart === 1'b1) nExec++;
	trs_responder DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmdIn(cmdIn), .resIn(resIn),
		.readStart(readStart), .byteAck(byteAck), .txByte(txByte), .status(status), .execStart(execStart));
	trs_host_model host (.sys_clk(sys_clk), .txByte(txByte), .readStart(readStart), .byteAck(byteAck));
	// ----
	// helpers
	// ----
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
		c ^= b;
		for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
		return c;
	endfunction : crc8
	function automatic logic [63:0] exp_resp(logic [7:0] st, int n, logic [39:0] d);
		logic [63:0] r;
		logic [7:0] c;
		r = {RESP_LEN{FILL_BYTE}};
		r[7:0] = st;
		c = crc8(CRC_INIT, st);
		for (int i = 0; i < n; i++) begin
			r[8*(i+1)+:8] = d[8*i+:8];
			c = crc8(c, d[8*i+:8]);
		end
		r[8*(n+1)+:8] = c;
		return r;
	endfunction : exp_resp
	task automatic read_chk(string what, logic [7:0] st, int n, logic [39:0] d);
		logic [63:0] r;
		bit hung;
		check({what, " status"}, 64'(status), 64'(st));
		host.do_read(r, hung);
		if (hung) begin
			fails++;
			$display("[ERR] %s handshake expected 1 seen 0", what);
			wrap_up();
		end
		check(what, r, exp_resp(st, n, d));
	endtask : read_chk
	task automatic send_cmd(logic bad);
		cmdIn = '{valid: 1'b1, bad: bad, isWrite: 1'($urandom)};
		@(negedge sys_clk);
		cmdIn = '0;
		repeat (3) @(negedge sys_clk);
	endtask : send_cmd
	task automatic send_res(logic ok, int n, logic [39:0] d);
		resIn = '{done: 1'b1, ok: ok, count: 3'(n), data: d};
		@(negedge sys_clk);
		resIn = '0;
		repeat (2) @(negedge sys_clk);
	endtask : send_res
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'h984A5953));
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		check("reset status", 64'(status), 64'h0);
		for (int t = 0; t < 4; t++) begin
			// corners first: full payload, then empty result
			cnt = (t == 0) ? PAY_MAX : (t == 1) ? 0 : int'($urandom_range(PAY_MAX, 1));
			pay = {8'($urandom), $urandom};
			e0 = nExec;
			send_cmd(1'b0);
			read_chk("pending read", 8'h01, 0, pay);
			read_chk("repeat read", 8'h01, 0, pay);
			if (t % 2 == 1) begin
				send_cmd(1'b0);
				read_chk("reject read", 8'h09, 0, pay);
				check("status after reject read", 64'(status), 64'h01);
			end
			check("start count", 64'(nExec - e0), 64'h1);
			send_res(t != 3, cnt, pay);
			read_chk("result read", (t == 3) ? 8'h02 : 8'h00, (t == 3) ? 0 : cnt, pay);
			send_cmd(1'b1);
			read_chk("bad read", 8'h02, 0, pay);
			check("start count after bad", 64'(nExec - e0), 64'h1);
			$display("test %0d done", t);
		end
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
